// *** verilog/tsio_port.sv ***
module tsio_port #(
    parameter int unsigned MIN_CYCLES  = tsio_pkg::MIN_WIDTH_CYC,
    parameter int unsigned PASS_CYCLES = tsio_pkg::PASS_CYC
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // connector inputs, active low
    input  wire logic [tsio_pkg::MSEL_W-1:0]   memSelectN,
    input  wire logic                          selectStrobeN,
    input  wire logic                          startN,
    input  wire logic                          stopN,
    input  wire logic                          enableN,
    // remote terminal inputs, active low
    input  wire logic                          remStartN,
    input  wire logic                          remStopN,
    // panel logic, same clock
    input  wire logic                          panelStart,
    input  wire logic                          panelStop,
    input  wire logic                          shiftKey,
    input  wire logic                          autoScreen,
    // measurement engine, same clock
    input  wire logic                          rampDone,
    input  wire logic                          judgePass,
    input  wire logic                          judgeUpperFail,
    input  wire logic                          judgeLowerFail,
    input  wire logic                          protectTrip,
    // open-drain outputs, enable high pulls pin low
    output logic                               testOnOe,
    output logic                               testActiveOe,
    output logic                               passOe,
    output logic                               upperFailOe,
    output logic                               lowerFailOe,
    output logic                               readyOe,
    output logic                               protectionOe,
    // to engine
    output logic                               testStart,
    output logic                               testHalt,
    output logic                               recallValid,
    output logic [6:0]                         recallNumber,
    output logic                               recallProgram,
    output logic                               factoryInit,
    // avalon-mm slave
    input  wire logic [tsio_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic [31:0]                        avs_readdata,
    output logic                               avs_waitrequest
);
    logic [tsio_pkg::PIN_N-1:0] act, acc;
    wire  logic [tsio_pkg::PIN_N-1:0] pinsN = {remStopN, remStartN, enableN, stopN, startN,
                                               selectStrobeN, memSelectN};

    // each pin gets its own filter instance; select data needs no width check
    genvar gi;
    generate
        for (gi = 0; gi < tsio_pkg::PIN_N; gi++) begin : g_pin
            tsio_input_filter #(
                .MIN_CYCLES ((gi < tsio_pkg::MSEL_W) ? 1 : MIN_CYCLES),
                .CNT_W      (tsio_pkg::MIN_CNT_W)
            ) u_filt (
                .clk      (clk),
                .rstn     (rstn),
                .pinN     (pinsN[gi]),
                .active   (act[gi]),
                .accepted (acc[gi])
            );
        end
    endgenerate

    tsio_pkg::tsio_state_t state_q, state_d;
    logic passHold_q, passHold_d, remote_q, remote_d;
    logic enPrev_q, strbPrev_q, pStartPrev_q, pStopPrev_q, powerUp_q;
    logic rampSeen_q, rampSeen_d, cause_q, cause_d;
    logic upper_q, upper_d, lower_q, lower_d;
    logic testOn_d, testAct_d, ready_d, prot_d, start_d, halt_d;
    logic recValid_d, recProg_d, reject_q, reject_d, factory_d;
    logic [6:0] recNum_d;
    logic enableLow, enChange, pStartRise, pStopRise, startReq, stopReq;
    logic protEvt, failEvt, passFire, strobeRise, digitsOk;
    logic [3:0] units, tens;

    assign enableLow  = act[tsio_pkg::PIN_ENABLE];
    assign enChange   = enableLow != enPrev_q;
    assign pStartRise = panelStart && !pStartPrev_q;
    assign pStopRise  = panelStop && !pStopPrev_q;
    // enable low hands start to connector and remote, panel locked out
    assign startReq = enableLow ?
        (acc[tsio_pkg::PIN_START] || (remote_q && acc[tsio_pkg::PIN_RSTART])) :
        (pStartRise || (remote_q && acc[tsio_pkg::PIN_RSTART]));
    assign stopReq  = acc[tsio_pkg::PIN_STOP] || pStopRise ||
                      (remote_q && acc[tsio_pkg::PIN_RSTOP]);
    assign protEvt  = enChange || protectTrip;
    assign failEvt  = judgeUpperFail || judgeLowerFail;
    assign passFire = (state_q == tsio_pkg::ST_TEST) && !protEvt && !stopReq && !failEvt && judgePass;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            tsio_pkg::ST_READY: begin
                if (protEvt) state_d = tsio_pkg::ST_PROTECT;
                else if (startReq) state_d = tsio_pkg::ST_TEST;
            end
            tsio_pkg::ST_TEST: begin
                if (protEvt) state_d = tsio_pkg::ST_PROTECT;
                else if (stopReq) state_d = tsio_pkg::ST_READY;
                else if (failEvt) state_d = tsio_pkg::ST_FAIL;
                else if (judgePass) state_d = tsio_pkg::ST_READY;
            end
            tsio_pkg::ST_FAIL: begin
                if (protEvt) state_d = tsio_pkg::ST_PROTECT;
                else if (stopReq) state_d = tsio_pkg::ST_READY;
            end
            tsio_pkg::ST_PROTECT: begin
                if (stopReq && !protEvt) state_d = tsio_pkg::ST_READY;
            end
        endcase
    end

    // status outputs follow the next state so they line up with state_q
    always_comb begin
        rampSeen_d = (state_d == tsio_pkg::ST_TEST) && (rampSeen_q || (rampDone && state_q == tsio_pkg::ST_TEST));
        testOn_d   = state_d == tsio_pkg::ST_TEST;
        testAct_d  = rampSeen_d;
        ready_d    = state_d == tsio_pkg::ST_READY;
        prot_d     = state_d == tsio_pkg::ST_PROTECT;
        cause_d    = prot_d && (cause_q || enChange);
        upper_d    = (state_d == tsio_pkg::ST_FAIL) &&
                     ((state_q == tsio_pkg::ST_FAIL) ? upper_q : judgeUpperFail);
        lower_d    = (state_d == tsio_pkg::ST_FAIL) &&
                     ((state_q == tsio_pkg::ST_FAIL) ? lower_q : judgeLowerFail);
        start_d    = (state_q == tsio_pkg::ST_READY) && (state_d == tsio_pkg::ST_TEST);
        halt_d     = (state_q == tsio_pkg::ST_TEST) && (protEvt || stopReq);
    end

    // recall on strobe release; code is active low so asserted bits read as ones
    assign strobeRise = strbPrev_q && !act[tsio_pkg::PIN_STROBE];
    assign units      = act[3:0];
    assign tens       = act[7:4];
    assign digitsOk   = (units <= tsio_pkg::BCD_MAX) && (tens <= tsio_pkg::BCD_MAX);

    always_comb begin
        recValid_d = strobeRise && digitsOk;
        recNum_d   = recallNumber;
        recProg_d  = recallProgram;
        reject_d   = reject_q;
        if (strobeRise) begin
            reject_d = !digitsOk;
            if (digitsOk) begin
                recNum_d  = 7'({3'h0, tens} * tsio_pkg::BCD_BASE + {3'h0, units});
                recProg_d = autoScreen;
            end
        end
        factory_d = powerUp_q && shiftKey;
    end

    // bus: waitrequest drops one cycle after a request, data taken then
    logic        wait_d;
    logic [31:0] rdata_d;
    logic        busAck;
    assign busAck = !avs_waitrequest && (avs_read || avs_write);

    always_comb begin
        wait_d     = !((avs_read || avs_write) && avs_waitrequest);
        rdata_d    = avs_readdata;
        passHold_d = passHold_q;
        remote_d   = remote_q;
        if (avs_read && avs_waitrequest) begin
            rdata_d = '0;
            unique case (avs_address)
                tsio_pkg::REG_CTRL: begin
                    rdata_d[tsio_pkg::CTRL_PASS_HOLD] = passHold_q;
                    rdata_d[tsio_pkg::CTRL_REMOTE]    = remote_q;
                end
                tsio_pkg::REG_STATUS: begin
                    rdata_d[1:0]                   = state_q;
                    rdata_d[tsio_pkg::ST_PROT_BIT]  = protectionOe;
                    rdata_d[tsio_pkg::ST_CAUSE_BIT] = cause_q;
                    rdata_d[tsio_pkg::ST_UPPER_BIT] = upperFailOe;
                    rdata_d[tsio_pkg::ST_LOWER_BIT] = lowerFailOe;
                    rdata_d[tsio_pkg::ST_PASS_BIT]  = passOe;
                end
                tsio_pkg::REG_RECALL: begin
                    rdata_d[6:0]                   = recallNumber;
                    rdata_d[tsio_pkg::RC_PROG_BIT]  = recallProgram;
                    rdata_d[tsio_pkg::RC_REJ_BIT]   = reject_q;
                end
                default: rdata_d = '0;
            endcase
        end
        if (avs_write && busAck && avs_address == tsio_pkg::REG_CTRL && avs_byteenable[0]) begin
            passHold_d = avs_writedata[tsio_pkg::CTRL_PASS_HOLD];
            remote_d   = avs_writedata[tsio_pkg::CTRL_REMOTE];
        end
        if (factory_d) begin
            passHold_d = tsio_pkg::CTRL_RESET[tsio_pkg::CTRL_PASS_HOLD];
            remote_d   = tsio_pkg::CTRL_RESET[tsio_pkg::CTRL_REMOTE];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q      <= tsio_pkg::ST_READY;
            passHold_q   <= tsio_pkg::CTRL_RESET[tsio_pkg::CTRL_PASS_HOLD];
            remote_q     <= tsio_pkg::CTRL_RESET[tsio_pkg::CTRL_REMOTE];
            enPrev_q     <= 1'b0;
            strbPrev_q   <= 1'b0;
            pStartPrev_q <= 1'b0;
            pStopPrev_q  <= 1'b0;
            powerUp_q    <= 1'b1;
            rampSeen_q   <= 1'b0;
            cause_q      <= 1'b0;
            upper_q      <= 1'b0;
            lower_q      <= 1'b0;
            reject_q     <= 1'b0;
            testOnOe     <= 1'b0;
            testActiveOe <= 1'b0;
            readyOe      <= 1'b1;
            protectionOe <= 1'b0;
            testStart    <= 1'b0;
            testHalt     <= 1'b0;
            recallValid  <= 1'b0;
            recallNumber <= '0;
            recallProgram <= 1'b0;
            factoryInit  <= 1'b0;
            avs_readdata <= '0;
            avs_waitrequest <= 1'b1;
        end else begin
            state_q      <= state_d;
            passHold_q   <= passHold_d;
            remote_q     <= remote_d;
            enPrev_q     <= enableLow;
            strbPrev_q   <= act[tsio_pkg::PIN_STROBE];
            pStartPrev_q <= panelStart;
            pStopPrev_q  <= panelStop;
            powerUp_q    <= 1'b0;
            rampSeen_q   <= rampSeen_d;
            cause_q      <= cause_d;
            upper_q      <= upper_d;
            lower_q      <= lower_d;
            reject_q     <= reject_d;
            testOnOe     <= testOn_d;
            testActiveOe <= testAct_d;
            readyOe      <= ready_d;
            protectionOe <= prot_d;
            testStart    <= start_d;
            testHalt     <= halt_d;
            recallValid  <= recValid_d;
            recallNumber <= recNum_d;
            recallProgram <= recProg_d;
            factoryInit  <= factory_d;
            avs_readdata <= rdata_d;
            avs_waitrequest <= wait_d;
        end
    end

    assign upperFailOe = upper_q;
    assign lowerFailOe = lower_q;

    // timed pass cannot be cut short; only a held pass is cleared
    tsio_hold_timer #(
        .HOLD_CYCLES (PASS_CYCLES),
        .CNT_W       (tsio_pkg::PASS_CNT_W)
    ) u_pass (
        .clk    (clk),
        .rstn   (rstn),
        .fire   (passFire),
        .holdOn (passHold_q),
        .clear  (passHold_q && (start_d || stopReq)),
        .active (passOe)
    );

    // helper for the pass width check
    logic [tsio_pkg::PASS_CNT_W-1:0] passLen_q;
    always_ff @(posedge clk) begin
        if (!rstn) passLen_q <= '0;
        else if (passFire) passLen_q <= '0;
        else if (passOe) passLen_q <= passLen_q + 1'b1;
    end

    sequence s_ready_start;
        state_q == tsio_pkg::ST_READY && startReq && !protEvt;
    endsequence
    sequence s_test_running;
        testStart && state_q == tsio_pkg::ST_TEST && !readyOe;
    endsequence

    a_ready_state: assert property (@(posedge clk) disable iff (!rstn)
        readyOe == (state_q == tsio_pkg::ST_READY)) else $error("ready output differs from state");
    a_prot_out: assert property (@(posedge clk) disable iff (!rstn)
        protectionOe == (state_q == tsio_pkg::ST_PROTECT)) else $error("protection output differs");
    a_start_drops_ready: assert property (@(posedge clk) disable iff (!rstn)
        s_ready_start |=> s_test_running) else $error("valid start did not begin test");
    a_enable_gates_start: assert property (@(posedge clk) disable iff (!rstn)
        state_q == tsio_pkg::ST_READY && !enableLow && !protEvt && !pStartRise && !remote_q
        |=> state_q == tsio_pkg::ST_READY) else $error("start taken while enable high");
    a_panel_ignored: assert property (@(posedge clk) disable iff (!rstn)
        enableLow && pStartRise && !acc[tsio_pkg::PIN_START] && !acc[tsio_pkg::PIN_RSTART]
        |=> !testStart) else $error("panel start accepted while enable low");
    a_enable_prot: assert property (@(posedge clk) disable iff (!rstn)
        enChange |=> protectionOe && cause_q) else $error("enable change missed protection");
    a_stop_clears: assert property (@(posedge clk) disable iff (!rstn)
        state_q == tsio_pkg::ST_PROTECT && stopReq && !protEvt |=> readyOe && !protectionOe)
        else $error("stop did not clear protection");
    a_upper_hold: assert property (@(posedge clk) disable iff (!rstn)
        upperFailOe && !stopReq && !protEvt |=> upperFailOe) else $error("upper fail dropped");
    a_lower_set: assert property (@(posedge clk) disable iff (!rstn)
        state_q == tsio_pkg::ST_TEST && judgeLowerFail && !protEvt && !stopReq |=> lowerFailOe)
        else $error("lower fail not shown");
    a_pass_width: assert property (@(posedge clk) disable iff (!rstn)
        $fell(passOe) && !$past(passHold_q) |-> passLen_q == tsio_pkg::PASS_CNT_W'(PASS_CYCLES))
        else $error("pass output width wrong");
    a_active_in_test: assert property (@(posedge clk) disable iff (!rstn)
        testActiveOe |-> testOnOe && rampSeen_q) else $error("test active outside ramped test");
    a_recall_bcd: assert property (@(posedge clk) disable iff (!rstn)
        strobeRise |=> recallValid == $past(digitsOk)) else $error("recall validity wrong");
    a_factory_init: assert property (@(posedge clk) disable iff (!rstn)
        powerUp_q && shiftKey |=> factoryInit ##1 !factoryInit) else $error("factory init not pulsed");
endmodule // tsio_port

// *** pkg/tsio_pkg.sv ***
// Function
// - select code is two active-low BCD digits
// - latch select on strobe rise, then recall
// - inputs active low, accepted only after 5 ms (select code lines are taken without a width check)
// - test-on whole test, test-active after ramp
// - pass at least 0.2 s, or held
// - upper fail held until cleared
// - lower fail held until cleared
// - ready output equals ready state
// - protection output while in protection
// - connector start begins a test
// - stop halts test or clears status
// - start-enable qualifies external start
// - remote option start/stop beside panel switches
// - shift at power-up restores factory settings
// - start-enable level change forces protection
// - 5 ms stop or panel stop clears protection
// - start after ready; ready drops on start
// - enable low: connector/remote start, panel ignored
package tsio_pkg;
    localparam int unsigned CLK_KHZ      = 100000;
    localparam int unsigned MIN_WIDTH_MS = 5;
    localparam int unsigned MIN_WIDTH_CYC = MIN_WIDTH_MS * CLK_KHZ;
    localparam int unsigned PASS_MIN_MS  = 200;
    localparam int unsigned PASS_CYC     = PASS_MIN_MS * CLK_KHZ;
    localparam int unsigned MIN_CNT_W    = 20;
    localparam int unsigned PASS_CNT_W   = 25;

    // synchronised pin vector positions
    localparam int unsigned MSEL_W     = 8;
    localparam int unsigned PIN_STROBE = 8;
    localparam int unsigned PIN_START  = 9;
    localparam int unsigned PIN_STOP   = 10;
    localparam int unsigned PIN_ENABLE = 11;
    localparam int unsigned PIN_RSTART = 12;
    localparam int unsigned PIN_RSTOP  = 13;
    localparam int unsigned PIN_N      = 14;

    // avalon register map, byte addresses
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_RECALL = 4'h8;
    localparam int unsigned CTRL_PASS_HOLD = 0;
    localparam int unsigned CTRL_REMOTE    = 1;
    localparam int unsigned ST_PROT_BIT    = 4;
    localparam int unsigned ST_CAUSE_BIT   = 5;
    localparam int unsigned ST_UPPER_BIT   = 6;
    localparam int unsigned ST_LOWER_BIT   = 7;
    localparam int unsigned ST_PASS_BIT    = 8;
    localparam int unsigned RC_PROG_BIT    = 8;
    localparam int unsigned RC_REJ_BIT     = 9;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // bcd handling
    localparam logic [3:0] BCD_MAX  = 4'h9;
    localparam logic [6:0] BCD_BASE = 7'h0A;

    typedef enum logic [1:0] {
        ST_READY,
        ST_TEST,
        ST_FAIL,
        ST_PROTECT
    } tsio_state_t;
endpackage

// *** verilog/tsio_input_filter.sv ***
module tsio_input_filter #(
    parameter int unsigned MIN_CYCLES = 1,
    parameter int unsigned CNT_W      = tsio_pkg::MIN_CNT_W
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // pin, active low
    input  wire logic pinN,
    // qualified level and acceptance pulse
    output logic      active,
    output logic      accepted
);
    logic             s1_q, s2_q, s3_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             act_q, act_d;
    // s3 trails s2 by one cycle, so the agreed span is one shorter than the pin's low time
    localparam int unsigned LAST_CNT = (MIN_CYCLES > 1) ? MIN_CYCLES - 2 : 0;

    // a change counts only once the last two stages agree
    always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (!s2_q && !s3_q) begin
            if (cnt_q == CNT_W'(LAST_CNT)) act_d = 1'b1;
            else cnt_d = cnt_q + 1'b1;
        end else if (s2_q && s3_q) begin
            cnt_d = '0;
            act_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            cnt_q <= '0;
            act_q <= 1'b0;
            accepted <= 1'b0;
        end else begin
            s1_q  <= pinN;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            cnt_q <= cnt_d;
            act_q <= act_d;
            accepted <= act_d && !act_q;
        end
    end

    assign active = act_q;
endmodule // tsio_input_filter

// *** verilog/tsio_hold_timer.sv ***
module tsio_hold_timer #(
    parameter int unsigned HOLD_CYCLES = tsio_pkg::PASS_CYC,
    parameter int unsigned CNT_W       = tsio_pkg::PASS_CNT_W
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // control
    input  wire logic fire,
    input  wire logic holdOn,
    input  wire logic clear,
    // stretched level
    output logic      active
);
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             on_d;

    // fire wins over clear so a fresh pass is never lost
    always_comb begin
        cnt_d = cnt_q;
        on_d  = active;
        if (fire) begin
            on_d  = 1'b1;
            cnt_d = '0;
        end else if (clear) begin
            on_d = 1'b0;
        end else if (active && !holdOn) begin
            if (cnt_q == CNT_W'(HOLD_CYCLES - 1)) on_d = 1'b0;
            else cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q  <= '0;
            active <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            active <= on_d;
        end
    end
endmodule // tsio_hold_timer

// *** tb/tsio_ctrl_model.sv ***
module tsio_ctrl_model (
    // clock
    input  wire logic        clk,
    // pins toward the tester, idle high as if pulled up
    output logic [5:0]       pinN,
    output logic [7:0]       memSelectN
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pinN = 6'h3F;
        memSelectN = 8'hFF;
    end
    // callers pass at least the minimum width, or less on purpose to be refused
    task automatic pulse(input int i, input int cyc);
        @(posedge clk);
        pinN[i] <= 1'b0;
        repeat (cyc) @(posedge clk);
        pinN[i] <= 1'b1;
    endtask
    task automatic level(input int i, input logic v);
        @(posedge clk);
        pinN[i] <= v;
    endtask
    // code stays put through the strobe; asserted bit drives the line low
    task automatic select(input logic [7:0] code, input int cyc);
        @(posedge clk);
        memSelectN <= ~code;
        pulse(3, cyc);
    endtask
endmodule // tsio_ctrl_model

// *** tb/tsio_port_tb_top.sv ***
module tsio_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MIN = 8;
    localparam int PW = MIN + 4;
    localparam int TON = 0, ACT = 1, PAS = 2, UPF = 3, RDY = 5, PRT = 6, RCL = 7;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        shift = 1'b0;
    logic [4:0]  eng = 5'h0;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata, rdData;
    logic        avsWaitrequest, recallProgram;
    logic [6:0]  recallNumber;
    wire  [10:0] outs;
    wire  [5:0]  pinN;
    wire  [7:0]  memSelectN;
    int          fails = 0;
    int          checkCount = 0;
    int          starts = 0;
    int          halts = 0;
    int          inits = 0;
    always #5 clk = ~clk;
    // pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        if (outs[8]) starts <= starts + 1;
        if (outs[9]) halts <= halts + 1;
        if (outs[10]) inits <= inits + 1;
    end
    tsio_ctrl_model ctl (.clk(clk), .pinN(pinN), .memSelectN(memSelectN));
    tsio_port #(.MIN_CYCLES(MIN), .PASS_CYCLES(20)) dut (
        .clk(clk), .rstn(rstn), .memSelectN(memSelectN), .selectStrobeN(pinN[3]), .startN(pinN[0]),
        .stopN(pinN[1]), .enableN(pinN[2]), .remStartN(pinN[4]), .remStopN(pinN[5]),
        .panelStart(eng[0]), .panelStop(1'b0), .shiftKey(shift), .autoScreen(1'b1), .rampDone(eng[1]),
        .judgePass(eng[2]), .judgeUpperFail(eng[3]), .judgeLowerFail(eng[4]), .protectTrip(1'b0),
        .testOnOe(outs[0]), .testActiveOe(outs[1]), .passOe(outs[2]), .upperFailOe(outs[3]),
        .lowerFailOe(outs[4]), .readyOe(outs[5]), .protectionOe(outs[6]), .testStart(outs[8]), .testHalt(outs[9]),
        .recallValid(outs[7]), .recallNumber(recallNumber), .recallProgram(recallProgram), .factoryInit(outs[10]),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bounded wait; a hang ends the run at once
    task automatic waitOut(input int i, input logic v);
        int k;
        for (k = 0; k < 300 && outs[i] !== v; k++) @(posedge clk);
        chk($sformatf("out%0d", i), {31'h0, v}, {31'h0, outs[i]});
        if (outs[i] !== v) test_done();
    endtask
    task automatic kick(input int i);
        @(posedge clk);
        eng[i] <= 1'b1;
        @(posedge clk);
        eng[i] <= 1'b0;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= wd;
        avsRead <= !wr;
        avsWrite <= wr;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avsWaitrequest === 1'b0) break;
        end
        rdData = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        chk("waitrequest", 32'h0, {31'h0, avsWaitrequest});
        if (k == 50) test_done();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("readyOe", 32'h1, {31'h0, outs[RDY]});
        bus(0, 4'h0, 32'h0);
        chk("ctrl", 32'h0, rdData);
        bus(1, 4'h0, 32'h2);
        bus(0, 4'h0, 32'h0);
        chk("ctrl", 32'h2, rdData);
        bus(0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, rdData);
        ctl.pulse(0, PW);
        repeat (4) @(posedge clk);
        chk("testOnOe", 32'h0, {31'h0, outs[TON]});
        ctl.level(2, 1'b0);
        waitOut(PRT, 1);
        chk("readyOe", 32'h0, {31'h0, outs[RDY]});
        bus(0, 4'h4, 32'h0);
        chk("cause", 32'h1, {31'h0, rdData[5]});
        ctl.pulse(1, MIN - 1);
        repeat (MIN) @(posedge clk);
        chk("protectionOe", 32'h1, {31'h0, outs[PRT]});
        ctl.pulse(1, MIN);
        waitOut(RDY, 1);
        chk("protectionOe", 32'h0, {31'h0, outs[PRT]});
        repeat (2 * MIN) @(posedge clk);
        kick(0);
        repeat (MIN) @(posedge clk);
        chk("testOnOe", 32'h0, {31'h0, outs[TON]});
        ctl.pulse(0, PW);
        waitOut(TON, 1);
        chk("readyOe", 32'h0, {31'h0, outs[RDY]});
        chk("testActiveOe", 32'h0, {31'h0, outs[ACT]});
        kick(1);
        waitOut(ACT, 1);
        kick(2);
        waitOut(PAS, 1);
        repeat (15) @(posedge clk);
        chk("passOe", 32'h1, {31'h0, outs[PAS]});
        waitOut(PAS, 0);
        waitOut(RDY, 1);
        // second round starts from the remote terminal and stops from it
        for (int i = 0; i < 2; i++) begin
            repeat (2 * MIN) @(posedge clk);
            ctl.pulse(i ? 4 : 0, PW);
            waitOut(TON, 1);
            kick(3 + i);
            waitOut(UPF + i, 1);
            repeat (30) @(posedge clk);
            chk("fail", 32'h1, {31'h0, outs[UPF + i]});
            chk("testOnOe", 32'h0, {31'h0, outs[TON]});
            ctl.pulse(i ? 5 : 1, PW);
            waitOut(RDY, 1);
            chk("fail", 32'h0, {31'h0, outs[UPF + i]});
        end
        repeat (2 * MIN) @(posedge clk);
        ctl.pulse(0, PW);
        waitOut(TON, 1);
        ctl.pulse(1, PW);
        waitOut(RDY, 1);
        chk("testOnOe", 32'h0, {31'h0, outs[TON]});
        ctl.select(8'h42, PW);
        waitOut(RCL, 1);
        chk("recallNumber", 32'h2A, {25'h0, recallNumber});
        chk("recallProgram", 32'h1, {31'h0, recallProgram});
        ctl.select(8'h3A, PW);
        repeat (2 * MIN) @(posedge clk);
        bus(0, 4'h8, 32'h0);
        chk("reject", 32'h1, {31'h0, rdData[9]});
        chk("testStart", 32'h4, starts);
        chk("testHalt", 32'h1, halts);
        shift <= 1'b1;
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("readyOe", 32'h1, {31'h0, outs[RDY]});
        bus(0, 4'h0, 32'h0);
        chk("ctrl", 32'h0, rdData);
        chk("factoryInit", 32'h1, inits);
        test_done();
    end
endmodule // tsio_port_tb_top
